// *** shared/dsf_pkg.sv ***
package dsf_pkg;
  // ----------------------------------------
  // semaphore space geometry
  // ----------------------------------------
  localparam int unsigned FLAG_COUNT = 8;
  localparam int unsigned FLAG_IDX_W = 3;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned ADDR_W = 19;
  localparam logic [0:0] FLAG_CLAIM = 1'h0;
  localparam logic [0:0] FLAG_FREE = 1'h1;
  // ----------------------------------------
  // pin timing in controller cycles
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ACCESS_NS = 20;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ACCESS_CYC_W4 = 4'(ACCESS_CYC);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSF_OP_CLAIM,
    DSF_OP_RELEASE,
    DSF_OP_POLL,
    DSF_OP_INIT
  } dsf_op_e;

  typedef struct packed {
    dsf_op_e op;
    logic [FLAG_IDX_W-1:0] flag;
  } dsf_cmd_s;

  typedef struct packed {
    logic semaphore_select_n;
    logic chip_enable_active_low;
    logic chip_enable_active_high;
    logic write_n;
    logic output_enable_n;
    logic [1:0] lower_upper_byte_enable_n;
    logic [ADDR_W-1:0] addr;
  } dsf_pins_s;
endpackage

// *** logic/dsf_owned_mem.sv ***
`timescale 1ns/1ns
// small record of which flags this side believes it holds
module dsf_owned_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic rd_data_o
);
  logic [DEPTH-1:0] mem_q;

  // storage, cleared at reset
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mem_q <= '0;
    end else if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read port
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 1'b0;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule

// *** logic/dsf_host.sv ***
`timescale 1ns/1ns
// Function
// (RQ1) eight flags, independent of RAM
// (RQ2) active low: zero claims, one releases
// (RQ3) select low, other pins as SRAM
// (RQ4) address bits 0-2 pick the flag
// (RQ5) only data bit zero is written
// (RQ6) zero on free flag: owner reads zero
// (RQ7) owner writes one frees flag
// (RQ8) foreign zero held in request latch
// (RQ9) pending requester still reads one
// (RQ10) freed flag passes to pending requester
// (RQ11) read replicates flag on all bits
// (RQ12) read asserts select, byte enables, output enable
// (RQ13) flag latched when read begins
// (RQ14) claim is write zero then read back
// (RQ15) failed claim: poll or withdraw
// (RQ16) earlier request wins, ties arbitrary
// (RQ17) software frees all eight flags first
// (RQ18) flags gate no hardware resource
// (RQ19) latches hold, tie-break deterministic
module dsf_host (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_valid_i,
  input wire dsf_pkg::dsf_cmd_s cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic granted_o,
  output logic init_done_o,
  output logic [dsf_pkg::FLAG_COUNT-1:0] owned_o,
  output dsf_pkg::dsf_pins_s pins_o,
  input wire logic [dsf_pkg::DATA_W-1:0] data_i,
  output logic [dsf_pkg::DATA_W-1:0] data_o,
  output logic data_oe_n_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_INIT_WR,
    ST_IDLE,
    ST_WR,
    ST_RD,
    ST_DONE
  } dsf_state_e;

  dsf_state_e state_q;
  dsf_pkg::dsf_cmd_s cmd_q;
  logic [3:0] cnt_q;
  logic [dsf_pkg::FLAG_IDX_W-1:0] init_idx_q;
  logic own_rd;
  logic own_wr;
  logic own_val;

  // level of bit 0 written on the data pins for each op
  function automatic logic write_value(input dsf_pkg::dsf_op_e op);
    return (op == dsf_pkg::DSF_OP_CLAIM) ? dsf_pkg::FLAG_CLAIM : dsf_pkg::FLAG_FREE;
  endfunction

  // a flag is held only if every data bit reads zero
  function automatic logic all_zero(input logic [dsf_pkg::DATA_W-1:0] d);
    return (d == '0);
  endfunction

  wire access_end = (cnt_q == dsf_pkg::ACCESS_CYC_W4 - 4'h1);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // init frees every flag (RQ17), claim writes then reads (RQ14)
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_INIT_WR;
      cmd_q <= '0;
      cnt_q <= 4'h0;
      init_idx_q <= '0;
    end else begin
      unique case (state_q)
        ST_INIT_WR: begin
          cnt_q <= access_end ? 4'h0 : cnt_q + 4'h1;
          if (access_end) begin
            init_idx_q <= init_idx_q + 3'h1;
            if (init_idx_q == 3'h7) begin
              state_q <= ST_IDLE; // RQ17
            end
          end
        end
        ST_IDLE: begin
          cnt_q <= 4'h0;
          if (cmd_valid_i) begin
            cmd_q <= cmd_i;
            state_q <= (cmd_i.op == dsf_pkg::DSF_OP_POLL) ? ST_RD : ST_WR; // RQ14 RQ15
          end
        end
        ST_WR: begin
          cnt_q <= access_end ? 4'h0 : cnt_q + 4'h1;
          if (access_end) begin
            state_q <= (cmd_q.op == dsf_pkg::DSF_OP_CLAIM) ? ST_RD : ST_DONE; // RQ14
          end
        end
        ST_RD: begin
          cnt_q <= access_end ? 4'h0 : cnt_q + 4'h1;
          if (access_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // semaphore space via select low, chip_enable_active_high set, chip_enable_active_low held high (RQ3)
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pins_o <= '{semaphore_select_n: 1'b1, chip_enable_active_low: 1'b1,
                  chip_enable_active_high: 1'b0, write_n: 1'b1, output_enable_n: 1'b1,
                  lower_upper_byte_enable_n: 2'h3, addr: '0};
      data_o <= '0;
      data_oe_n_o <= 1'b1;
    end else begin
      pins_o.semaphore_select_n <= 1'b1;
      pins_o.chip_enable_active_low <= 1'b1;
      pins_o.chip_enable_active_high <= 1'b0;
      pins_o.write_n <= 1'b1;
      pins_o.output_enable_n <= 1'b1;
      pins_o.lower_upper_byte_enable_n <= 2'h3;
      data_oe_n_o <= 1'b1;
      if (state_q == ST_INIT_WR || state_q == ST_WR) begin
        pins_o.semaphore_select_n <= 1'b0; // RQ3
        pins_o.chip_enable_active_high <= 1'b1;
        pins_o.lower_upper_byte_enable_n <= 2'h0;
        pins_o.write_n <= 1'b0;
        pins_o.addr <= {16'h0000, (state_q == ST_INIT_WR) ? init_idx_q : cmd_q.flag}; // RQ4
        data_o <= {17'h00000, (state_q == ST_INIT_WR) ? dsf_pkg::FLAG_FREE
                                                        : write_value(cmd_q.op)}; // RQ2 RQ5
        data_oe_n_o <= 1'b0;
      end else if (state_q == ST_RD) begin
        pins_o.semaphore_select_n <= 1'b0; // RQ12
        pins_o.chip_enable_active_high <= 1'b1;
        pins_o.lower_upper_byte_enable_n <= 2'h0;
        pins_o.output_enable_n <= 1'b0;
        pins_o.addr <= {16'h0000, cmd_q.flag}; // RQ4
      end
    end
  end

  // ----------------------------------------
  // result
  // ----------------------------------------
  // sample replicated flag at end of read (RQ11 RQ13)
  wire rd_sample = (state_q == ST_RD) && access_end;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      granted_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      init_done_o <= 1'b0;
    end else begin
      done_o <= (state_q == ST_DONE);
      cmd_ready_o <= (state_q == ST_IDLE) && !cmd_valid_i;
      init_done_o <= init_done_o || (state_q == ST_IDLE);
      if (rd_sample) begin
        granted_o <= all_zero(data_i); // RQ11 RQ6 RQ9
      end else if (state_q == ST_WR) begin
        granted_o <= 1'b0;
      end
    end
  end

  // owned record for software; advisory only, gates nothing (RQ18)
  // release and init both free the flag, so both clear the record
  assign own_wr = rd_sample || (state_q == ST_WR && cmd_q.op != dsf_pkg::DSF_OP_CLAIM);
  assign own_val = rd_sample && all_zero(data_i);
  dsf_owned_mem #(.DEPTH(dsf_pkg::FLAG_COUNT), .AW(dsf_pkg::FLAG_IDX_W)) u_owned (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(own_wr),
    .wr_addr_i(cmd_q.flag),
    .wr_data_i(own_val),
    .rd_addr_i(cmd_q.flag),
    .rd_data_o(own_rd)
  );

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      owned_o <= '0;
    end else if (own_wr) begin
      owned_o[cmd_q.flag] <= own_val; // RQ1
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_phase;
    state_q == ST_WR && cmd_q.op == dsf_pkg::DSF_OP_CLAIM;
  endsequence
  sequence s_read_phase;
    state_q == ST_RD;
  endsequence

  AST_CLAIM_ORDER: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ14
    s_write_phase ##1 state_q != ST_WR |-> s_read_phase)
    else $error("claim did not read back after write");
  AST_READ_PINS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ12
    $fell(pins_o.output_enable_n) |-> !pins_o.semaphore_select_n
      && pins_o.lower_upper_byte_enable_n == 2'h0 && pins_o.write_n)
    else $error("read without select and byte enables");
  AST_WRITE_BIT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ5
    !pins_o.write_n |-> data_o[dsf_pkg::DATA_W-1:1] == '0 && !data_oe_n_o)
    else $error("write drives more than bit zero");
  AST_ADDR_RANGE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ4
    !pins_o.semaphore_select_n |-> pins_o.addr[dsf_pkg::ADDR_W-1:3] == '0)
    else $error("high address bits set in semaphore access");
  AST_SELECT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ3
    !pins_o.semaphore_select_n |-> pins_o.chip_enable_active_low
      && pins_o.chip_enable_active_high)
    else $error("semaphore access with array enabled");
  AST_INIT_FREE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ17
    state_q == ST_INIT_WR && cnt_q == 4'h0 |=> data_o[0] == dsf_pkg::FLAG_FREE)
    else $error("init did not write one");
  AST_DONE_PULSE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ15
    done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_GRANT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ11
    rd_sample |=> granted_o == ($past(data_i) == '0))
    else $error("grant does not follow read data");
  AST_OWN_MIRROR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // RQ1
    state_q == ST_DONE |=> own_rd == owned_o[cmd_q.flag])
    else $error("owned record and memory copy disagree");
endmodule

// *** test/dsf_dev_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// behavioural semaphore device: left port on host pins, right port on bench
// ----------------------------------------
module dsf_dev_model (
  input wire logic core_clk_i,
  input wire dsf_pkg::dsf_pins_s pins_i,
  input wire logic [dsf_pkg::DATA_W-1:0] data_i,
  input wire logic data_oe_n_i,
  output logic [dsf_pkg::DATA_W-1:0] data_o,
  input wire logic r_wr_i,
  input wire logic [2:0] r_idx_i,
  input wire logic r_d0_i,
  output logic r_flag_o,
  output logic bad_o
);
  logic [7:0] req_l_q = 8'h00; // eight latches, no power-up clear
  logic [7:0] req_r_q = 8'hff;
  logic [7:0] own_l_q = 8'h00;
  logic [7:0] own_r_q = 8'h00;
  logic [7:0] nl;
  logic [7:0] nr;
  logic rd_v_q = 1'h1;
  logic rd_q = 1'h0;
  logic bad_q = 1'h0;
  logic sel;
  logic rd;
  logic wr;
  logic [2:0] idx;
  // decode; flags gate nothing else in the device
  assign sel = !pins_i.semaphore_select_n && pins_i.chip_enable_active_high;
  assign idx = pins_i.addr[2:0];
  assign rd = sel && !pins_i.output_enable_n;
  assign wr = sel && !pins_i.write_n && !data_oe_n_i;
  assign r_flag_o = !own_r_q[r_idx_i];
  assign bad_o = bad_q;
  // replicated flag during a read, inverse of it once the bus is released
  assign data_o = {dsf_pkg::DATA_W{(rd && !rd_q) ? !own_l_q[idx] : rd_v_q}}
    ^ {dsf_pkg::DATA_W{!rd}};
  // request latches take data bit zero only
  always_comb begin
    nl = req_l_q;
    nr = req_r_q;
    if (wr) nl[idx] = data_i[0];
    if (r_wr_i) nr[r_idx_i] = r_d0_i;
  end
  // capture at read start, ownership resolution, left wins a tie
  always_ff @(posedge core_clk_i) begin
    rd_q <= rd;
    if (rd && !rd_q) rd_v_q <= !own_l_q[idx];
    bad_q <= bad_q || (rd && pins_i.lower_upper_byte_enable_n != 2'h0);
    req_l_q <= nl;
    req_r_q <= nr;
    for (int i = 0; i < 8; i++) begin
      if (own_l_q[i]) begin
        if (nl[i]) begin
          own_l_q[i] <= 1'h0;
          own_r_q[i] <= !nr[i];
        end
      end else if (own_r_q[i]) begin
        if (nr[i]) begin
          own_r_q[i] <= 1'h0;
          own_l_q[i] <= !nl[i];
        end
      end else begin
        own_l_q[i] <= !nl[i];
        own_r_q[i] <= nl[i] && !nr[i];
      end
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
  logic core_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic cmd_valid_i = 1'h0;
  dsf_pkg::dsf_cmd_s cmd_i = 5'h00;
  logic cmd_ready_o, done_o, granted_o, init_done_o, data_oe_n_o, r_flag, bad;
  logic [7:0] owned_o;
  dsf_pkg::dsf_pins_s pins_o;
  logic [17:0] data_i, data_o;
  logic r_wr = 1'h0;
  logic [2:0] r_idx = 3'h0;
  logic r_d0 = 1'h1;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // clock, instances, timeout
  // ----------------------------------------
  initial forever #5 core_clk_i = ~core_clk_i;
  dsf_host u_dsf_host (.core_clk_i, .reset_n_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .done_o,
    .granted_o, .init_done_o, .owned_o, .pins_o, .data_i, .data_o, .data_oe_n_o);
  dsf_dev_model u_dsf_dev_model (.core_clk_i, .pins_i(pins_o), .data_i(data_o),
    .data_oe_n_i(data_oe_n_o), .data_o(data_i), .r_wr_i(r_wr), .r_idx_i(r_idx),
    .r_d0_i(r_d0), .r_flag_o(r_flag), .bad_o(bad));
  task automatic final_report();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic run(input dsf_pkg::dsf_op_e op, input logic [2:0] f);
    int n = 0;
    while (cmd_ready_o !== 1'h1 && n < 50) begin tick(); n++; end
    `CHK(cmd_ready_o, 1'h1)
    @(posedge core_clk_i);
    cmd_i <= '{op: op, flag: f};
    cmd_valid_i <= 1'h1;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'h0;
    n = 0;
    while (done_o !== 1'h1 && n < 20) begin tick(); n++; end
    `CHK(done_o, 1'h1)
  endtask
  task automatic r_write(input logic [2:0] f, input logic v);
    @(posedge core_clk_i);
    r_wr <= 1'h1;
    r_idx <= f;
    r_d0 <= v;
    @(posedge core_clk_i);
    r_wr <= 1'h0;
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_pending();
    run(dsf_pkg::DSF_OP_CLAIM, 3'h3);
    `CHK(granted_o, 1'h1)
    `CHK(owned_o, 8'h08)
    r_write(3'h3, 1'h0);
    `CHK(r_flag, 1'h1)
    run(dsf_pkg::DSF_OP_RELEASE, 3'h3);
    `CHK(owned_o, 8'h00)
    `CHK(r_flag, 1'h0)
    run(dsf_pkg::DSF_OP_POLL, 3'h3);
    `CHK(granted_o, 1'h0)
    r_write(3'h3, 1'h1);
    $display("test pending done");
  endtask
  task automatic t_foreign();
    r_write(3'h5, 1'h0);
    run(dsf_pkg::DSF_OP_CLAIM, 3'h5);
    `CHK(granted_o, 1'h0)
    `CHK(owned_o, 8'h00)
    r_write(3'h5, 1'h1);
    run(dsf_pkg::DSF_OP_POLL, 3'h5);
    `CHK(granted_o, 1'h1)
    `CHK(owned_o, 8'h20)
    run(dsf_pkg::DSF_OP_INIT, 3'h5);
    `CHK(u_dsf_dev_model.req_l_q, 8'hff)
    `CHK(owned_o, 8'h00)
    $display("test foreign done");
  endtask
  task automatic t_all();
    for (int f = 0; f < 8; f++) run(dsf_pkg::DSF_OP_CLAIM, 3'(f));
    `CHK(owned_o, 8'hff)
    for (int f = 0; f < 8; f++) run(dsf_pkg::DSF_OP_RELEASE, 3'(f));
    `CHK(owned_o, 8'h00)
    `CHK(bad, 1'h0)
    $display("test all flags done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    `CHK(pins_o.semaphore_select_n, 1'h1)
    `CHK(data_oe_n_o, 1'h1)
    reset_n_i <= 1'h1;
    for (int n = 0; n < 40 && init_done_o !== 1'h1; n++) tick();
    `CHK(init_done_o, 1'h1)
    `CHK(u_dsf_dev_model.req_l_q, 8'hff)
    $display("test init done");
    t_pending();
    t_foreign();
    t_all();
    final_report();
  end
endmodule
